//--- rtl/uhr_host_rx.sv
// host receive endpoint control and status, reached over APB
// assumes a link engine on the same clock reporting handshakes and packet arrivals as one-cycle pulses
// Functional notes
// - toggle write needs enable; enable self-clears
// - read returns current receive data toggle
// - toggle writes ignored while enable low
// - toggle clear resets data toggle to zero
// - stall handshake sets flag and interrupt
// - in request issues IN; cleared on packet
// - flush drops head packet, clears ready unless another is buffered
// - flush ignored unless packet ready set
// - iso crc error flag follows packet ready
// - bulk nak limit halts endpoint, sets flag
// - three empty tries set error, interrupt
// - error reads zero in iso mode
// - full flag when no packet fits
// - packet ready sets flag and interrupt
// - endpoint zero count, seven bits
// - receive count, thirteen bits
// - speed field bits seven to six
// - speed codes: 1 high, 2 full, 3 low
`timescale 1ns/1ns
`default_nettype none
`include "uhr_defs.svh"
module uhr_host_rx #(
    parameter int SLOTS = 2,
    parameter int NAK_LIMIT_W = 8
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // link engine events
    input wire logic LINK_DATA,
    input wire logic [12:0] LINK_BYTES,
    input wire logic LINK_CRC_ERR,
    input wire logic LINK_TOGGLE,
    input wire logic LINK_NAK,
    input wire logic LINK_STALL,
    input wire logic LINK_TIMEOUT,
    input wire logic LINK_POP,
    // link engine request
    output logic IN_ISSUE,
    output logic [1:0] TARGET_SPEED,
    // interrupt
    output logic IRQ
);
    uhr_cnt_if cif ();
    uhr_pkg::uhr_state_e st_reg;
    uhr_pkg::uhr_prot_e prot_reg;
    logic [NAK_LIMIT_W-1:0] nak_limit_reg;
    logic [NAK_LIMIT_W-1:0] nak_cnt_reg;
    logic [1:0] tries_reg;
    logic tog_wren_reg, tog_reg, stall_reg, inreq_reg, errnak_reg, error_reg, rxrdy_reg;
    logic [1:0] speed_reg;
    logic [3:0] irq_stat_reg, irq_mask_reg;
    logic [31:0] rdata_next;
    logic wr, rd, hit, issue;
    logic iso;
    logic pkt_in, flush_go;

    function automatic logic sel(input logic [11:0] a, input logic [11:0] off);
        sel = (a == off);
    endfunction : sel

    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && !PWRITE;
    assign hit = sel(PADDR, `UHR_OFF_CSR) || sel(PADDR, `UHR_OFF_CNT0) || sel(PADDR, `UHR_OFF_RXCNT)
        || sel(PADDR, `UHR_OFF_TYPE0) || sel(PADDR, `UHR_OFF_CFG) || sel(PADDR, `UHR_OFF_IRQ_STAT)
        || sel(PADDR, `UHR_OFF_IRQ_MASK);
    assign iso = (prot_reg == uhr_pkg::UHR_PROT_ISO);
    assign pkt_in = LINK_DATA && (st_reg == uhr_pkg::UHR_ST_WAIT) && !cif.full;
    assign flush_go = wr && sel(PADDR, `UHR_OFF_CSR) && PWDATA[`UHR_B_FLUSH] && rxrdy_reg;
    assign issue = (st_reg == uhr_pkg::UHR_ST_IDLE) && inreq_reg && !errnak_reg && !error_reg && !stall_reg;

    uhr_rx_count #(.SLOTS(SLOTS)) u_cnt (
        .clk(CLK),
        .reset(RESET),
        .c(cif)
    );
    assign cif.push = pkt_in;
    assign cif.push_bytes = LINK_BYTES;
    assign cif.pop = LINK_POP && rxrdy_reg && !flush_go;
    assign cif.flush = flush_go;

    // transaction sequencer
    always_ff @(posedge CLK) begin
        if (RESET) begin
            st_reg <= uhr_pkg::UHR_ST_IDLE;
            nak_cnt_reg <= '0;
            tries_reg <= 2'h0;
        end else begin
            unique case (st_reg)
                uhr_pkg::UHR_ST_IDLE: begin
                    if (issue) begin
                        st_reg <= uhr_pkg::UHR_ST_WAIT;
                    end
                end
                uhr_pkg::UHR_ST_WAIT: begin
                    if (pkt_in || LINK_STALL) begin
                        st_reg <= uhr_pkg::UHR_ST_IDLE;
                        nak_cnt_reg <= '0;
                        tries_reg <= 2'h0;
                    end else if (LINK_NAK) begin
                        if (!iso && nak_limit_reg > 1 && nak_cnt_reg + 1'b1 >= nak_limit_reg) begin
                            st_reg <= uhr_pkg::UHR_ST_HALT;
                            nak_cnt_reg <= '0;
                        end else begin
                            nak_cnt_reg <= nak_cnt_reg + 1'b1;
                            st_reg <= uhr_pkg::UHR_ST_IDLE;
                        end
                    end else if (LINK_TIMEOUT) begin
                        st_reg <= uhr_pkg::UHR_ST_IDLE;
                        // iso has no retry accounting
                        if (!iso) begin
                            tries_reg <= (tries_reg + 2'h1 >= `UHR_MAX_TRIES) ? 2'h0 : tries_reg + 2'h1;
                        end
                    end
                end
                uhr_pkg::UHR_ST_HALT: begin
                    if (!errnak_reg) begin
                        st_reg <= uhr_pkg::UHR_ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign IN_ISSUE = issue;

    // control and status flags; hardware set wins over software clear
    always_ff @(posedge CLK) begin
        if (RESET) begin
            tog_wren_reg <= 1'b0;
            tog_reg <= 1'b0;
            stall_reg <= 1'b0;
            inreq_reg <= 1'b0;
            errnak_reg <= 1'b0;
            error_reg <= 1'b0;
            rxrdy_reg <= 1'b0;
        end else begin
            // the enable stands one cycle after the write that used it, then drops by itself
            if (tog_wren_reg) tog_wren_reg <= 1'b0;
            if (wr && sel(PADDR, `UHR_OFF_CSR)) begin
                if (PWDATA[`UHR_B_TOGWREN]) begin
                    tog_reg <= PWDATA[`UHR_B_TOG];
                    tog_wren_reg <= 1'b1;
                end
                if (PWDATA[`UHR_B_TOGCLR]) begin
                    tog_reg <= 1'b0;
                end
                if (!PWDATA[`UHR_B_STALL]) stall_reg <= 1'b0;
                inreq_reg <= PWDATA[`UHR_B_INREQ];
                if (!PWDATA[`UHR_B_ERRNAK] && !iso) errnak_reg <= 1'b0;
                if (!PWDATA[`UHR_B_ERROR]) error_reg <= 1'b0;
                if (!PWDATA[`UHR_B_RXRDY] || flush_go) begin
                    // a second buffered packet moves up and is ready at once
                    rxrdy_reg <= flush_go && cif.more;
                    if (iso) errnak_reg <= 1'b0;
                end
            end
            if (cif.pop) begin
                rxrdy_reg <= cif.more;
                if (iso) errnak_reg <= 1'b0;
            end
            if (pkt_in) begin
                tog_reg <= LINK_TOGGLE;
                rxrdy_reg <= 1'b1;
                inreq_reg <= 1'b0;
                if (iso && LINK_CRC_ERR) errnak_reg <= 1'b1;
            end
            if (st_reg == uhr_pkg::UHR_ST_WAIT && LINK_STALL) begin
                stall_reg <= 1'b1;
                inreq_reg <= 1'b0;
            end
            if (st_reg == uhr_pkg::UHR_ST_WAIT && LINK_NAK && !iso && nak_limit_reg > 1
                && nak_cnt_reg + 1'b1 >= nak_limit_reg) begin
                errnak_reg <= 1'b1;
            end
            if (st_reg == uhr_pkg::UHR_ST_WAIT && LINK_TIMEOUT && !iso && tries_reg + 2'h1 >= `UHR_MAX_TRIES) begin
                error_reg <= 1'b1;
                inreq_reg <= 1'b0;
            end
        end
    end

    // configuration registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            speed_reg <= 2'h0;
            prot_reg <= uhr_pkg::UHR_PROT_BULK;
            nak_limit_reg <= '0;
            irq_mask_reg <= 4'h0;
        end else if (wr) begin
            if (sel(PADDR, `UHR_OFF_TYPE0)) speed_reg <= PWDATA[`UHR_SPEED_HI:`UHR_SPEED_LO];
            if (sel(PADDR, `UHR_OFF_CFG)) begin
                prot_reg <= uhr_pkg::uhr_prot_e'(PWDATA[17:16]);
                nak_limit_reg <= PWDATA[NAK_LIMIT_W-1:0];
            end
            if (sel(PADDR, `UHR_OFF_IRQ_MASK)) irq_mask_reg <= PWDATA[3:0];
        end
    end

    assign TARGET_SPEED = speed_reg;

    // sticky interrupt status, write one to clear, set wins
    always_ff @(posedge CLK) begin
        if (RESET) begin
            irq_stat_reg <= 4'h0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~((wr && sel(PADDR, `UHR_OFF_IRQ_STAT)) ? PWDATA[3:0] : 4'h0))
                | {errnak_ev(), (st_reg == uhr_pkg::UHR_ST_WAIT && LINK_TIMEOUT && !iso
                && tries_reg + 2'h1 >= `UHR_MAX_TRIES), (st_reg == uhr_pkg::UHR_ST_WAIT && LINK_STALL),
                pkt_in};
        end
    end

    function automatic logic errnak_ev();
        errnak_ev = st_reg == uhr_pkg::UHR_ST_WAIT && LINK_NAK && !iso && nak_limit_reg > 1
            && nak_cnt_reg + 1'b1 >= nak_limit_reg;
    endfunction : errnak_ev

    always_ff @(posedge CLK) begin
        if (RESET) IRQ <= 1'b0;
        else IRQ <= |((irq_stat_reg) & irq_mask_reg);
    end

    // read mux; reserved bits return zero
    always_comb begin
        rdata_next = 32'h00000000;
        if (sel(PADDR, `UHR_OFF_CSR)) begin
            rdata_next[`UHR_B_TOG] = tog_reg;
            rdata_next[`UHR_B_STALL] = stall_reg;
            rdata_next[`UHR_B_INREQ] = inreq_reg;
            rdata_next[`UHR_B_ERRNAK] = errnak_reg;
            rdata_next[`UHR_B_ERROR] = error_reg && !iso;
            rdata_next[`UHR_B_FULL] = cif.full;
            rdata_next[`UHR_B_RXRDY] = rxrdy_reg;
        end else if (sel(PADDR, `UHR_OFF_CNT0)) begin
            rdata_next[6:0] = cif.count[6:0];
        end else if (sel(PADDR, `UHR_OFF_RXCNT)) begin
            rdata_next[12:0] = cif.count;
        end else if (sel(PADDR, `UHR_OFF_TYPE0)) begin
            rdata_next[`UHR_SPEED_HI:`UHR_SPEED_LO] = speed_reg;
        end else if (sel(PADDR, `UHR_OFF_CFG)) begin
            rdata_next[17:16] = prot_reg;
            rdata_next[NAK_LIMIT_W-1:0] = nak_limit_reg;
        end else if (sel(PADDR, `UHR_OFF_IRQ_STAT)) begin
            rdata_next[3:0] = irq_stat_reg;
        end else if (sel(PADDR, `UHR_OFF_IRQ_MASK)) begin
            rdata_next[3:0] = irq_mask_reg;
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) PRDATA <= 32'h00000000;
        else if (rd && !PENABLE) PRDATA <= rdata_next;
    end

    // no wait states: setup, then access completes
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;

    property p_stall_irq;
        @(posedge CLK) disable iff (RESET)
            (st_reg == uhr_pkg::UHR_ST_WAIT && LINK_STALL) |=> stall_reg && irq_stat_reg[`UHR_IRQ_STALL];
    endproperty
    a_stall_irq: assert property (p_stall_irq) else $error("stall not flagged");

    property p_inreq_clr;
        @(posedge CLK) disable iff (RESET)
            pkt_in |=> !inreq_reg && rxrdy_reg;
    endproperty
    a_inreq_clr: assert property (p_inreq_clr) else $error("in request not cleared");

    property p_err_iso;
        @(posedge CLK) disable iff (RESET)
            (iso && sel(PADDR, `UHR_OFF_CSR)) |-> !rdata_next[`UHR_B_ERROR];
    endproperty
    a_err_iso: assert property (p_err_iso) else $error("error visible in iso");

    property p_flush;
        @(posedge CLK) disable iff (RESET)
            (flush_go && !pkt_in) |=> rxrdy_reg == $past(cif.more);
    endproperty
    a_flush: assert property (p_flush) else $error("flush left wrong ready state");

    property p_tog_keep;
        @(posedge CLK) disable iff (RESET)
            (wr && sel(PADDR, `UHR_OFF_CSR) && !PWDATA[`UHR_B_TOGWREN] && !PWDATA[`UHR_B_TOGCLR] && !pkt_in)
            |=> $stable(tog_reg);
    endproperty
    a_tog_keep: assert property (p_tog_keep) else $error("toggle changed without enable");

    property p_tog_clr;
        @(posedge CLK) disable iff (RESET)
            (wr && sel(PADDR, `UHR_OFF_CSR) && PWDATA[`UHR_B_TOGCLR] && !pkt_in) |=> !tog_reg;
    endproperty
    a_tog_clr: assert property (p_tog_clr) else $error("toggle not cleared");

    property p_wren_clr;
        @(posedge CLK) disable iff (RESET)
            (wr && sel(PADDR, `UHR_OFF_CSR) && PWDATA[`UHR_B_TOGWREN] && !PWDATA[`UHR_B_TOGCLR] && !pkt_in)
            |=> tog_wren_reg && tog_reg == $past(PWDATA[`UHR_B_TOG]) ##1 !tog_wren_reg;
    endproperty
    a_wren_clr: assert property (p_wren_clr) else $error("toggle enable stuck or value lost");

    property p_halt;
        @(posedge CLK) disable iff (RESET)
            errnak_ev() |=> errnak_reg && st_reg == uhr_pkg::UHR_ST_HALT;
    endproperty
    a_halt: assert property (p_halt) else $error("nak limit did not halt");

    property p_err_irq;
        @(posedge CLK) disable iff (RESET)
            (st_reg == uhr_pkg::UHR_ST_WAIT && LINK_TIMEOUT && !iso && tries_reg == 2'h2)
            |=> error_reg && irq_stat_reg[`UHR_IRQ_ERROR];
    endproperty
    a_err_irq: assert property (p_err_irq) else $error("third empty try not flagged");

    property p_rx_irq;
        @(posedge CLK) disable iff (RESET)
            pkt_in |=> irq_stat_reg[`UHR_IRQ_RXRDY];
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("packet arrival not in status");

    property p_issue_pulse;
        @(posedge CLK) disable iff (RESET)
            IN_ISSUE |=> !IN_ISSUE;
    endproperty
    a_issue_pulse: assert property (p_issue_pulse) else $error("in issue longer than one cycle");

    c_pkt: cover property (@(posedge CLK) pkt_in);
    c_halt: cover property (@(posedge CLK) st_reg == uhr_pkg::UHR_ST_HALT);
    c_full: cover property (@(posedge CLK) cif.full);
    c_stall: cover property (@(posedge CLK) st_reg == uhr_pkg::UHR_ST_WAIT && LINK_STALL);
    c_flush_next: cover property (@(posedge CLK) flush_go && cif.more);
endmodule : uhr_host_rx
`default_nettype wire

//--- pkg/uhr_defs.svh
// register offsets, field positions, interrupt bits and the retry count for the host receive endpoint block
// assumes inclusion by bare name from design files
`ifndef UHR_DEFS_SVH
`define UHR_DEFS_SVH
`define UHR_OFF_CSR 12'h000
`define UHR_OFF_CNT0 12'h004
`define UHR_OFF_RXCNT 12'h008
`define UHR_OFF_TYPE0 12'h00C
`define UHR_OFF_CFG 12'h010
`define UHR_OFF_IRQ_STAT 12'h014
`define UHR_OFF_IRQ_MASK 12'h018
`define UHR_B_TOGWREN 10
`define UHR_B_TOG 9
`define UHR_B_TOGCLR 7
`define UHR_B_STALL 6
`define UHR_B_INREQ 5
`define UHR_B_FLUSH 4
`define UHR_B_ERRNAK 3
`define UHR_B_ERROR 2
`define UHR_B_FULL 1
`define UHR_B_RXRDY 0
`define UHR_SPEED_HI 7
`define UHR_SPEED_LO 6
`define UHR_MAX_TRIES 2'h3
`define UHR_IRQ_RXRDY 0
`define UHR_IRQ_STALL 1
`define UHR_IRQ_ERROR 2
`define UHR_IRQ_NAKTO 3
`endif

//--- pkg/uhr_pkg.sv
// types shared by the host receive endpoint block
// assumes nothing beyond a SystemVerilog compiler
package uhr_pkg;
    typedef enum logic [1:0] {
        UHR_SPD_ILLEGAL = 2'h0,
        UHR_SPD_HIGH = 2'h1,
        UHR_SPD_FULL = 2'h2,
        UHR_SPD_LOW = 2'h3
    } uhr_speed_e;
    typedef enum logic [1:0] {
        UHR_PROT_CTRL = 2'h0,
        UHR_PROT_ISO = 2'h1,
        UHR_PROT_BULK = 2'h2,
        UHR_PROT_INTR = 2'h3
    } uhr_prot_e;
    typedef enum {
        UHR_ST_IDLE,
        UHR_ST_WAIT,
        UHR_ST_HALT
    } uhr_state_e;
endpackage : uhr_pkg

//--- pkg/uhr_cnt_if.sv
// interface carrying receive fifo occupancy events between the top and its counter
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface uhr_cnt_if;
    logic push;
    logic [12:0] push_bytes;
    logic pop;
    logic flush;
    logic [12:0] count;
    logic full;
    logic more;
    modport top (output push, output push_bytes, output pop, output flush, input count, input full, input more);
    modport cnt (input push, input push_bytes, input pop, input flush, output count, output full, output more);
endinterface : uhr_cnt_if
`default_nettype wire

//--- rtl/uhr_rx_count.sv
// receive byte counter and packet slot tracker
// assumes events arrive on the same clock; at most two packet slots
`timescale 1ns/1ns
`default_nettype none
module uhr_rx_count #(
    parameter int SLOTS = 2
) (
    input wire logic clk,
    input wire logic reset,
    uhr_cnt_if.cnt c
);
    logic [1:0] slots_reg;
    logic [12:0] count_reg;
    logic [12:0] next_len_reg;

    always_ff @(posedge clk) begin
        if (reset) begin
            slots_reg <= 2'h0;
            count_reg <= 13'h0000;
            next_len_reg <= 13'h0000;
        end else if ((c.flush || c.pop) && c.push) begin
            // a push only reaches a free slot, so the head leaves and the new packet takes its place
            count_reg <= c.push_bytes;
        end else if (c.flush || c.pop) begin
            // the second slot's length moves up to the head
            slots_reg <= (slots_reg != 2'h0) ? slots_reg - 2'h1 : 2'h0;
            count_reg <= (slots_reg == 2'h2) ? next_len_reg : 13'h0000;
            next_len_reg <= 13'h0000;
        end else if (c.push && (32'(slots_reg) < SLOTS)) begin
            slots_reg <= slots_reg + 2'h1;
            if (slots_reg == 2'h0) begin
                count_reg <= c.push_bytes;
            end else begin
                next_len_reg <= c.push_bytes;
            end
        end
    end

    assign c.count = count_reg;
    assign c.full = (32'(slots_reg) >= SLOTS);
    assign c.more = (slots_reg > 2'h1);
endmodule : uhr_rx_count
`default_nettype wire

//--- verification/uhr_link_model.sv
// link partner model: answers each IN issue after a short delay with data, NAK, STALL or a timeout
// assumes the block's clock; the bench picks the answer before it raises the request
`timescale 1ns/1ns
`default_nettype none
module uhr_link_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // request and answer choice
    input wire logic in_issue,
    input wire logic [1:0] kind,
    input wire logic [12:0] bytes,
    input wire logic crc,
    input wire logic tog,
    // answers toward the block
    output logic data,
    output logic [12:0] nbytes,
    output logic crc_err,
    output logic toggle,
    output logic nak,
    output logic stall,
    output logic tmo
);
    logic busy_reg;
    logic [2:0] wait_reg;
    always_ff @(posedge clk) begin
        {data, crc_err, nak, stall, tmo} <= 5'h00;
        // length and toggle wander outside a data pulse so a stale value is never trusted
        nbytes <= ~nbytes;
        toggle <= ~toggle;
        if (reset) begin
            busy_reg <= 1'b0;
            wait_reg <= 3'h0;
            nbytes <= 13'h0000;
            toggle <= 1'b0;
        end else if (busy_reg && wait_reg != 3'h0) begin
            wait_reg <= wait_reg - 3'h1;
        end else if (busy_reg) begin
            busy_reg <= 1'b0;
            case (kind)
                2'h0: begin
                    data <= 1'b1;
                    nbytes <= bytes;
                    crc_err <= crc;
                    toggle <= tog;
                end
                2'h1: nak <= 1'b1;
                2'h2: stall <= 1'b1;
                default: tmo <= 1'b1;
            endcase
        end else if (in_issue) begin
            busy_reg <= 1'b1;
            // low length bits vary the delay, so both prompt and slow answers occur
            wait_reg <= {1'b0, bytes[1:0]};
        end
    end
endmodule : uhr_link_model
`default_nettype wire

//--- verification/tb_top.sv
// self-checking bench: APB register traffic and link answers for the host receive endpoint block
// assumes the link partner model answers each IN issue; expectations follow the field layout
`timescale 1ns/1ns
`default_nettype none
`include "uhr_defs.svh"
module tb_top;
    typedef struct {logic [11:0] a; logic [31:0] w; logic [31:0] m; logic [31:0] e;} uhr_row_s;
    localparam logic [11:0] csr_a = `UHR_OFF_CSR;
    localparam logic [11:0] st_a = `UHR_OFF_IRQ_STAT;
    localparam logic [11:0] mk_a = `UHR_OFF_IRQ_MASK;
    localparam logic [11:0] ty_a = `UHR_OFF_TYPE0;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic link_pop = 1'b0;
    logic [1:0] m_kind = 2'h0;
    logic [12:0] m_bytes = 13'h0;
    logic m_crc = 1'b0;
    logic m_tog = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, in_issue, irq, l_data, l_crc, l_tog, l_nak, l_stall, l_tmo, err;
    logic [12:0] l_bytes;
    logic [1:0] spd;
    logic [31:0] rd;
    int mismatches = 0;
    int n_compared = 0;
    int n_issue = 0;
    int k;
    uhr_row_s rows [10] = '{
        '{ty_a, 32'hFF, 32'hFFFF, 32'hC0},
        '{ty_a, 32'h40, 32'hFFFF, 32'h40},
        '{ty_a, 32'h80, 32'hFFFF, 32'h80},
        '{ty_a, 32'hC0, 32'hFFFF, 32'hC0},
        '{csr_a, 32'h600, 32'h7FF, 32'h200},
        '{csr_a, 32'h100, 32'h7FF, 32'h200},
        '{csr_a, 32'h400, 32'h7FF, 32'h000},
        '{csr_a, 32'h200, 32'h7FF, 32'h000},
        '{csr_a, 32'h600, 32'h7FF, 32'h200},
        '{csr_a, 32'h080, 32'h7FF, 32'h000}
    };
    uhr_host_rx #(.SLOTS(2), .NAK_LIMIT_W(8)) dut_u (.CLK(clk), .RESET(reset), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LINK_DATA(l_data), .LINK_BYTES(l_bytes),
        .LINK_CRC_ERR(l_crc), .LINK_TOGGLE(l_tog), .LINK_NAK(l_nak), .LINK_STALL(l_stall),
        .LINK_TIMEOUT(l_tmo), .LINK_POP(link_pop), .IN_ISSUE(in_issue), .TARGET_SPEED(spd), .IRQ(irq));
    uhr_link_model model_u (.clk(clk), .reset(reset), .in_issue(in_issue), .kind(m_kind),
        .bytes(m_bytes), .crc(m_crc), .tog(m_tog), .data(l_data), .nbytes(l_bytes), .crc_err(l_crc),
        .toggle(l_tog), .nak(l_nak), .stall(l_stall), .tmo(l_tmo));
    always #4 clk = ~clk;
    always @(posedge clk) if (in_issue === 1'b1) n_issue <= n_issue + 1;
    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] w);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= w;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] w);
        apb(1'b1, a, w);
    endtask : wr
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic rdchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd & m);
    endtask : rdchk
    // polls the control register until a bit reaches a level, bounded
    task automatic wait_bit(input int b, input logic v);
        apb(1'b0, csr_a, 32'h0);
        for (int i = 0; i < 300 && rd[b] !== v; i++) apb(1'b0, csr_a, 32'h0);
    endtask : wait_bit
    task automatic req(input logic [1:0] kd, input logic [12:0] n, input logic [31:0] keep);
        m_kind <= kd;
        m_bytes <= n;
        wr(csr_a, 32'h20 | keep);
    endtask : req
    task automatic settle;
        repeat (2) @(posedge clk);
    endtask : settle
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rdchk(csr_a, 32'hFFFF, 32'h0, "csr_rst");
        rdchk(`UHR_OFF_RXCNT, 32'hFFFF, 32'h0, "cnt_rst");
        apb(1'b0, 12'h01C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rdchk(rows[i].a, rows[i].m, rows[i].e, "row");
            if (rows[i].a == ty_a) chk("speed", {30'h0, rows[i].e[7:6]}, {30'h0, spd});
        end
        wr(mk_a, 32'hF);
        m_tog <= 1'b1;
        req(2'h0, 13'h5, 32'h0);
        wait_bit(`UHR_B_RXRDY, 1'b1);
        chk("rx_ready", 32'h201, rd & 32'h221);
        rdchk(`UHR_OFF_CNT0, 32'hFFFF, 32'h5, "cnt0");
        rdchk(`UHR_OFF_RXCNT, 32'hFFFF, 32'h5, "rxcnt");
        rdchk(st_a, 32'hF, 32'h1, "stat_rx");
        chk("irq_rx", 32'h1, {31'h0, irq});
        @(posedge clk);
        link_pop <= 1'b1;
        @(posedge clk);
        link_pop <= 1'b0;
        wr(st_a, 32'h1);
        wr(csr_a, 32'h0);
        settle();
        chk("irq_off", 32'h0, {31'h0, irq});
        req(2'h0, 13'h4, 32'h0);
        wait_bit(`UHR_B_RXRDY, 1'b1);
        req(2'h0, 13'h7, 32'h1);
        wait_bit(`UHR_B_FULL, 1'b1);
        chk("full", 32'h3, rd & 32'h3);
        rdchk(`UHR_OFF_RXCNT, 32'hFFFF, 32'h4, "head");
        wr(csr_a, 32'h11);
        rdchk(csr_a, 32'h3, 32'h1, "not_full");
        rdchk(`UHR_OFF_RXCNT, 32'hFFFF, 32'h7, "next");
        wr(csr_a, 32'h11);
        rdchk(csr_a, 32'h3, 32'h0, "flushed");
        wr(st_a, 32'hF);
        wr(mk_a, 32'h0);
        req(2'h2, 13'h0, 32'h0);
        wait_bit(`UHR_B_STALL, 1'b1);
        rdchk(st_a, 32'hF, 32'h2, "stat_stall");
        chk("irq_masked", 32'h0, {31'h0, irq});
        wr(mk_a, 32'h2);
        settle();
        chk("irq_stall", 32'h1, {31'h0, irq});
        wr(st_a, 32'h2);
        wr(csr_a, 32'h0);
        rdchk(csr_a, 32'h40, 32'h0, "stall_clr");
        chk("irq_clr", 32'h0, {31'h0, irq});
        wr(mk_a, 32'h4);
        k = n_issue;
        req(2'h3, 13'h0, 32'h0);
        wait_bit(`UHR_B_ERROR, 1'b1);
        repeat (10) @(posedge clk);
        chk("tries", 32'h3, 32'(n_issue - k));
        chk("irq_err", 32'h1, {31'h0, irq});
        rdchk(csr_a, 32'h4, 32'h4, "err_bulk");
        wr(`UHR_OFF_CFG, 32'h1_0000);
        rdchk(csr_a, 32'h4, 32'h0, "err_hidden");
        wr(csr_a, 32'h0);
        wr(st_a, 32'hF);
        wr(`UHR_OFF_CFG, 32'h2_0002);
        req(2'h1, 13'h1, 32'h0);
        wait_bit(`UHR_B_ERRNAK, 1'b1);
        k = n_issue;
        repeat (20) @(posedge clk);
        chk("halted", 32'h0, 32'(n_issue - k));
        wr(csr_a, 32'h0);
        rdchk(csr_a, 32'h8, 32'h0, "nak_clr");
        wr(`UHR_OFF_CFG, 32'h1_0000);
        k = n_issue;
        req(2'h3, 13'h2, 32'h0);
        for (int i = 0; i < 300 && n_issue - k < 5; i++) @(posedge clk);
        rdchk(csr_a, 32'h4, 32'h0, "iso_err");
        wr(csr_a, 32'h0);
        // an answer may still be in flight; let it land before the answer kind changes
        repeat (8) @(posedge clk);
        m_crc <= 1'b1;
        req(2'h0, 13'h3, 32'h0);
        wait_bit(`UHR_B_RXRDY, 1'b1);
        chk("iso_crc", 32'h9, rd & 32'h9);
        wr(csr_a, 32'h11);
        rdchk(csr_a, 32'h9, 32'h0, "crc_clr");
        wr(ty_a, 32'hC0);
        @(posedge clk);
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        rdchk(ty_a, 32'hFF, 32'h0, "type_rst");
        chk("irq_rst", 32'h0, {31'h0, irq});
        close_out();
    end
endmodule : tb_top
`default_nettype wire
